// file: logic/hsa_regs.svh
// Register map, field positions, reset values and sizes of the hue/saturation stage
`ifndef HSA_REGS_SVH
`define HSA_REGS_SVH
`define HSA_OFS_CTRL    8'h00
`define HSA_OFS_HUE     8'h04
`define HSA_OFS_SAT     8'h08
`define HSA_OFS_CMD     8'h0C
`define HSA_OFS_STAT    8'h10
`define HSA_BIT_EN      0
`define HSA_BIT_RAW     1
`define HSA_BIT_BAYER   2
`define HSA_SEL_LSB     4
`define HSA_SEL_MSB     6
`define HSA_LS_LSB      8
`define HSA_LS_MSB      10
`define HSA_BIT_RST     0
`define HSA_NCOLORS     3'h6
`define HSA_HUE_NEUTRAL 8'h00
`define HSA_SAT_NEUTRAL 8'h80
`define HSA_HUE_FULL    8'h80
`define HSA_GAIN_SHIFT  7
`define HSA_HUE_TUNG    8'h04
`define HSA_SAT_TUNG    8'h88
`define HSA_HUE_DAY     8'hFE
`define HSA_SAT_DAY     8'h90
`define HSA_HUE_D65     8'h00
`define HSA_SAT_D65     8'h8C
`define HSA_RESP_OK     2'h0
`define HSA_RESP_ERR    2'h2
`define HSA_FIFO_DEPTH  8
`define HSA_PIX_W       24
`define HSA_CHAN_MAX    11'h0FF
`endif

// file: logic/hsa_pkg.sv
// Types shared by the hue/saturation stage
package hsa_pkg;
  typedef logic [7:0] hsa_chan_t;
  typedef logic [2:0] hsa_corner_t;
  typedef enum logic [2:0] {
    HSA_LS_OFF  = 3'h0,
    HSA_LS_TUNG = 3'h1,
    HSA_LS_DAY  = 3'h2,
    HSA_LS_D65  = 3'h3,
    HSA_LS_CUST = 3'h4
  } hsa_light_t;
endpackage

// file: logic/hsa_adjust.sv
// Hue and saturation adjustment stage with register slave and output FIFO
// Notes on behaviour
// - Six colors each keep hue and saturation; a selector picks which one is accessed.
// - One enable turns the whole adjustment on or off.
// - Hue spans -4.0 to +3.96875 in fractional terms.
// - Raw hue is signed 8 bits, five fraction bits, +32 means +1.0.
// - Saturation spans 0.0 to +1.99219 in fractional terms.
// - Raw saturation is unsigned 8 bits, 128 means unity gain.
// - Bayer output without processed raw leaves pixels untouched.
// - Bayer output with processed raw still gets the adjustment.
// - Non-Bayer output ignores processed raw; only the enable counts.
// - Each color's settings act where that color predominates.
// - Adjusting one color partly touches its two hexagon neighbours.
// - Hue rotates a color toward a neighbour corner, fully at the negative limit.
// - Negative red hue goes toward yellow, positive toward magenta.
// - More saturation adds colour; zero saturation leaves gray.
// - Reset command loads settings of the chosen light source preset.
//
// The implementer's own choices: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/10ps
`include "hsa_regs.svh"

module hsa_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 8
) (
  input  wire logic             i_sys_clk,
  input  wire logic             i_rst_n,
  // Fill side
  input  wire logic             i_valid,
  input  wire logic [WIDTH-1:0] i_data,
  output logic                  o_ready,
  // Drain side
  output logic                  o_valid,
  output logic [WIDTH-1:0]      o_data,
  input  wire logic             i_ready,
  // Level
  output logic [$clog2(DEPTH):0] o_count
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic             push;
  logic             pop;

  // Honest flags straight from the level
  assign o_ready = (o_count != DEPTH[AW:0]);
  assign o_valid = (o_count != '0);
  assign push    = i_valid && o_ready;
  assign pop     = o_valid && i_ready;
  assign o_data  = mem[rd_ptr];

  // Storage has no reset; only the pointers matter
  always_ff @(posedge i_sys_clk) begin
    if (push) begin
      mem[wr_ptr] <= i_data;
    end
  end

  // Pointers and level
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_ptr  <= '0;
      rd_ptr  <= '0;
      o_count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      o_count <= o_count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  fifo_level_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    o_count <= DEPTH[AW:0]) else $error("fifo level above depth");
endmodule

module hsa_adjust (
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst_n,
  // AXI4-Lite write address and data
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  // AXI4-Lite write response
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  // AXI4-Lite read
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [7:0]  s_axi_araddr,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  // Incoming RGB pixels
  input  wire logic        i_pix_valid,
  output logic             o_pix_ready,
  input  wire logic [7:0]  i_pix_r,
  input  wire logic [7:0]  i_pix_g,
  input  wire logic [7:0]  i_pix_b,
  // Outgoing RGB pixels
  output logic             o_pix_valid,
  input  wire logic        i_pix_ready,
  output logic [7:0]       o_pix_r,
  output logic [7:0]       o_pix_g,
  output logic [7:0]       o_pix_b
);
  logic [7:0]  hue [6];
  logic [7:0]  sat [6];
  logic        adj_en;
  logic        raw_en;
  logic        bayer;
  logic [2:0]  sel;
  logic [2:0]  light;
  logic        aw_held;
  logic [7:0]  aw_addr;
  logic        w_held;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        do_wr;
  logic        active;
  logic        st_v;
  logic [7:0]  st_r;
  logic [7:0]  st_g;
  logic [7:0]  st_b;
  logic        take;
  logic        fifo_rdy;
  logic [3:0]  fifo_cnt;
  logic [7:0]  next_r;
  logic [7:0]  next_g;
  logic [7:0]  next_b;

  // Preset hue for a light source; off and custom are neutral
  function automatic logic [7:0] preset_hue(input logic [2:0] ls);
    case (ls)
      hsa_pkg::HSA_LS_TUNG: preset_hue = `HSA_HUE_TUNG;
      hsa_pkg::HSA_LS_DAY:  preset_hue = `HSA_HUE_DAY;
      hsa_pkg::HSA_LS_D65:  preset_hue = `HSA_HUE_D65;
      default:              preset_hue = `HSA_HUE_NEUTRAL;
    endcase
  endfunction

  // Preset saturation for a light source
  function automatic logic [7:0] preset_sat(input logic [2:0] ls);
    case (ls)
      hsa_pkg::HSA_LS_TUNG: preset_sat = `HSA_SAT_TUNG;
      hsa_pkg::HSA_LS_DAY:  preset_sat = `HSA_SAT_DAY;
      hsa_pkg::HSA_LS_D65:  preset_sat = `HSA_SAT_D65;
      default:              preset_sat = `HSA_SAT_NEUTRAL;
    endcase
  endfunction

  // Corner reached by rotating one step; negative hue moves up the ring
  function automatic hsa_pkg::hsa_corner_t step(input hsa_pkg::hsa_corner_t c,
                                                input logic neg);
    if (neg) begin
      step = (c == 3'h5) ? 3'h0 : c + 3'h1;
    end else begin
      step = (c == 3'h0) ? 3'h5 : c - 3'h1;
    end
  endfunction

  // Write channels are held independently, so either may come first
  assign s_axi_awready = !aw_held;
  assign s_axi_wready  = !w_held;
  assign do_wr         = aw_held && w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
      w_held  <= 1'b0;
      w_data  <= 32'h00000000;
      w_strb  <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (do_wr) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb; // Held with the data; the master may drop it after W
      end else if (do_wr) begin
        w_held <= 1'b0;
      end
    end
  end

  // Write response; offsets above the status register answer with an error
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `HSA_RESP_OK;
    end else if (do_wr) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (aw_addr > `HSA_OFS_STAT) ? `HSA_RESP_ERR : `HSA_RESP_OK;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Control word; only the low byte lanes carry fields
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      adj_en <= 1'b0;
      raw_en <= 1'b0;
      bayer  <= 1'b0;
      sel    <= 3'h0;
      light  <= hsa_pkg::HSA_LS_OFF;
    end else if (do_wr && aw_addr == `HSA_OFS_CTRL) begin
      if (w_strb[0]) begin
        adj_en <= w_data[`HSA_BIT_EN];
        raw_en <= w_data[`HSA_BIT_RAW];
        bayer  <= w_data[`HSA_BIT_BAYER];
        sel    <= w_data[`HSA_SEL_MSB:`HSA_SEL_LSB];
      end
      if (w_strb[1]) begin
        light <= w_data[`HSA_LS_MSB:`HSA_LS_LSB];
      end
    end
  end

  // Per-color settings; a selector past magenta reaches nothing
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int k = 0; k < 6; k++) begin
        hue[k] <= `HSA_HUE_NEUTRAL;
        sat[k] <= `HSA_SAT_NEUTRAL;
      end
    end else if (do_wr && aw_addr == `HSA_OFS_CMD && w_strb[0]
                 && w_data[`HSA_BIT_RST]) begin
      for (int k = 0; k < 6; k++) begin
        hue[k] <= preset_hue(light);
        sat[k] <= preset_sat(light);
      end
    end else if (do_wr && w_strb[0] && sel < `HSA_NCOLORS) begin
      if (aw_addr == `HSA_OFS_HUE) begin
        hue[sel] <= w_data[7:0];
      end
      if (aw_addr == `HSA_OFS_SAT) begin
        sat[sel] <= w_data[7:0];
      end
    end
  end

  // Read answer one cycle after the address; hue reads sign extended
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `HSA_RESP_OK;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= `HSA_RESP_OK;
      s_axi_rdata  <= 32'h00000000;
      case (s_axi_araddr)
        `HSA_OFS_CTRL: s_axi_rdata <= {21'h0, light, 1'b0, sel, 1'b0,
                                       bayer, raw_en, adj_en};
        `HSA_OFS_HUE:  if (sel < `HSA_NCOLORS) begin
          s_axi_rdata <= {{24{hue[sel][7]}}, hue[sel]};
        end
        `HSA_OFS_SAT:  if (sel < `HSA_NCOLORS) begin
          s_axi_rdata <= {24'h0, sat[sel]};
        end
        `HSA_OFS_CMD:  s_axi_rdata <= 32'h00000000;
        `HSA_OFS_STAT: s_axi_rdata <= {26'h0, fifo_cnt, st_v, active};
        default:       s_axi_rresp <= `HSA_RESP_ERR;
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Bayer output needs processed raw; other formats ignore it
  assign active = adj_en && (!bayer || raw_en);

  // Split pixel into gray, dominant primary and neighbouring secondary
  always_comb begin
    logic [7:0]  mx;
    logic [7:0]  md;
    logic [7:0]  mn;
    logic [2:0]  cp;
    logic [2:0]  cs;
    logic [7:0]  amt_in [2];
    logic [2:0]  cor [2];
    logic [10:0] acc [6];
    logic [15:0] gain;
    logic [8:0]  xs;
    logic [7:0]  mag;
    logic [16:0] keep;
    logic [10:0] rs;
    logic [10:0] gs;
    logic [10:0] bs;
    mx = 8'h00;
    md = 8'h00;
    mn = 8'h00;
    cp = 3'h0;
    cs = 3'h1;
    gain = 16'h0000;
    xs = 9'h000;
    mag = 8'h00;
    keep = 17'h00000;
    acc = '{default: 11'h000};
    amt_in = '{default: 8'h00};
    cor = '{default: 3'h0};
    rs = 11'h000;
    gs = 11'h000;
    bs = 11'h000;
    // Dominant channel picks the primary, the runner-up the secondary
    if (i_pix_r >= i_pix_g && i_pix_r >= i_pix_b) begin
      mx = i_pix_r;
      cp = 3'h0;
      if (i_pix_g >= i_pix_b) begin
        md = i_pix_g; mn = i_pix_b; cs = 3'h1;
      end else begin
        md = i_pix_b; mn = i_pix_g; cs = 3'h5;
      end
    end else if (i_pix_g >= i_pix_b) begin
      mx = i_pix_g;
      cp = 3'h2;
      if (i_pix_r >= i_pix_b) begin
        md = i_pix_r; mn = i_pix_b; cs = 3'h1;
      end else begin
        md = i_pix_b; mn = i_pix_r; cs = 3'h3;
      end
    end else begin
      mx = i_pix_b;
      cp = 3'h4;
      if (i_pix_g >= i_pix_r) begin
        md = i_pix_g; mn = i_pix_r; cs = 3'h3;
      end else begin
        md = i_pix_r; mn = i_pix_g; cs = 3'h5;
      end
    end
    amt_in[0] = mx - md;
    amt_in[1] = md - mn;
    cor[0] = cp;
    cor[1] = cs;
    // Scale each part by its gain, then split it toward the neighbour corner
    for (int k = 0; k < 2; k++) begin
      gain = amt_in[k] * sat[cor[k]];
      xs   = gain[`HSA_GAIN_SHIFT+8:`HSA_GAIN_SHIFT];
      mag  = hue[cor[k]][7] ? 8'(-hue[cor[k]]) : hue[cor[k]];
      keep = xs * (`HSA_HUE_FULL - mag);
      acc[cor[k]] = acc[cor[k]] + 11'(keep[`HSA_GAIN_SHIFT+8:`HSA_GAIN_SHIFT]);
      acc[step(cor[k], hue[cor[k]][7])] = acc[step(cor[k], hue[cor[k]][7])]
          + 11'(xs - keep[`HSA_GAIN_SHIFT+8:`HSA_GAIN_SHIFT]);
    end
    // Rebuild channels from corners that contain each primary
    rs = 11'(mn) + acc[0] + acc[1] + acc[5];
    gs = 11'(mn) + acc[1] + acc[2] + acc[3];
    bs = 11'(mn) + acc[3] + acc[4] + acc[5];
    next_r = (rs > `HSA_CHAN_MAX) ? 8'hFF : rs[7:0];
    next_g = (gs > `HSA_CHAN_MAX) ? 8'hFF : gs[7:0];
    next_b = (bs > `HSA_CHAN_MAX) ? 8'hFF : bs[7:0];
  end

  // One register stage either way, so bypass keeps the latency
  assign o_pix_ready = !st_v || fifo_rdy;
  assign take        = i_pix_valid && o_pix_ready;

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_v <= 1'b0;
      st_r <= 8'h00;
      st_g <= 8'h00;
      st_b <= 8'h00;
    end else if (o_pix_ready) begin
      st_v <= i_pix_valid;
      if (i_pix_valid) begin
        st_r <= active ? next_r : i_pix_r;
        st_g <= active ? next_g : i_pix_g;
        st_b <= active ? next_b : i_pix_b;
      end
    end
  end

  // Output buffer absorbs formatter stalls and pushes back upstream
  hsa_fifo #(
    .WIDTH (`HSA_PIX_W),
    .DEPTH (`HSA_FIFO_DEPTH)
  ) u_fifo (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .i_valid   (st_v),
    .i_data    ({st_r, st_g, st_b}),
    .o_ready   (fifo_rdy),
    .o_valid   (o_pix_valid),
    .o_data    ({o_pix_r, o_pix_g, o_pix_b}),
    .i_ready   (i_pix_ready),
    .o_count   (fifo_cnt)
  );

  logic all_neutral;
  always_comb begin
    all_neutral = 1'b1;
    for (int k = 0; k < 6; k++) begin
      if (hue[k] != `HSA_HUE_NEUTRAL || sat[k] != `HSA_SAT_NEUTRAL) begin
        all_neutral = 1'b0;
      end
    end
  end

  bypass_pass_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    take && !active |=> st_v && st_r == $past(i_pix_r) && st_g == $past(i_pix_g)
    && st_b == $past(i_pix_b)) else $error("disabled stage altered a pixel");
  bayer_gate_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    take && bayer && !raw_en |=> st_r == $past(i_pix_r) && st_g == $past(i_pix_g)
    && st_b == $past(i_pix_b)) else $error("bayer without raw adjusted");
  raw_bayer_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    take && adj_en && bayer && raw_en && sat[0] == 8'h00 && i_pix_r > i_pix_g
    && i_pix_g == i_pix_b |=> st_r == $past(i_pix_b))
    else $error("processed raw not adjusted");
  neutral_ident_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    take && all_neutral |=> st_r == $past(i_pix_r) && st_g == $past(i_pix_g)
    && st_b == $past(i_pix_b)) else $error("neutral settings changed a pixel");
  gray_keep_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    take && i_pix_r == i_pix_g && i_pix_g == i_pix_b |=> st_g == $past(i_pix_g))
    else $error("gray pixel not kept");
  sel_write_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    do_wr && aw_addr == `HSA_OFS_SAT && w_strb[0] && sel < `HSA_NCOLORS
    |=> sat[$past(sel)] == $past(w_data[7:0])) else $error("saturation write lost");
  hue_sign_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    s_axi_arvalid && s_axi_arready && s_axi_araddr == `HSA_OFS_HUE
    |=> s_axi_rdata[31:8] == {24{s_axi_rdata[7]}}) else $error("hue read not signed");
  preset_load_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    do_wr && aw_addr == `HSA_OFS_CMD && w_strb[0] && w_data[`HSA_BIT_RST]
    |=> sat[0] == preset_sat($past(light)) && hue[5] == preset_hue($past(light)))
    else $error("reset command missed preset");
  stall_hold_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    st_v && !fifo_rdy |=> $stable(st_r) && st_v) else $error("stage lost under stall");
endmodule

// file: sim/hsa_pix_sink.sv
// Pixel sink model standing in for the output formatter
`timescale 1ns/10ps

module hsa_pix_sink (
  // Clock and reset
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst_n,
  // Pacing from the bench
  input  wire logic        i_stall,
  input  wire logic        i_slow,
  // Pixel stream
  input  wire logic        i_valid,
  input  wire logic [23:0] i_data,
  output logic             o_ready
);
  logic [23:0] q[$];
  logic        hs;
  logic [23:0] seen;

  // Ready is a flop; slow mode takes only every other cycle to stress the FIFO
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_ready <= 1'b0;
    end else begin
      o_ready <= !i_stall && !(i_slow && o_ready);
    end
  end

  // Sample mid-cycle so the handshake never races the edge
  always @(negedge i_sys_clk) begin
    hs = i_valid && o_ready;
    seen = i_data;
  end

  // Store every pixel taken, in order
  always @(posedge i_sys_clk) begin
    if (hs) begin
      q.push_back(seen);
    end
  end
endmodule

// file: sim/testbench.sv
// Self-checking bench of the hue/saturation stage
`timescale 1ns/10ps
`include "hsa_regs.svh"

module testbench;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
  logic [7:0]  awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0;
  logic        pv = 1'b0, stall = 1'b0, slow = 1'b0;
  logic [23:0] pin = 24'h0;
  wire         awr, wr, bv, arr, rv, opr, opv, sry;
  wire  [1:0]  br, rr;
  wire  [31:0] rd;
  wire  [23:0] pout;
  int          errors = 0;
  int          n_tests = 0;
  int          cyc = 0;

  hsa_adjust dut (
    .i_sys_clk(clk), .i_rst_n(rst_n),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa),
    .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF),
    .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_bresp(br),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara),
    .s_axi_rvalid(rv), .s_axi_rready(rry), .s_axi_rdata(rd), .s_axi_rresp(rr),
    .i_pix_valid(pv), .o_pix_ready(opr),
    .i_pix_r(pin[23:16]), .i_pix_g(pin[15:8]), .i_pix_b(pin[7:0]),
    .o_pix_valid(opv), .i_pix_ready(sry),
    .o_pix_r(pout[23:16]), .o_pix_g(pout[15:8]), .o_pix_b(pout[7:0])
  );

  hsa_pix_sink snk (
    .i_sys_clk(clk), .i_rst_n(rst_n), .i_stall(stall), .i_slow(slow),
    .i_valid(opv), .i_data(pout), .o_ready(sry)
  );

  // 50 MHz clock
  always #10 clk = ~clk;

  // Hang guard, far above the less than a thousand cycles the run needs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      end_of_test;
    end
  end

  task automatic end_of_test;
    if (errors == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask

  // Write: address and data offered together, each dropped once taken
  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ta = 1'b0;
    logic tw = 1'b0;
    @(posedge clk);
    awv <= 1'b1;
    awa <= a;
    wv <= 1'b1;
    wd <= d;
    bry <= 1'b1;
    while (!(ta && tw)) begin
      @(negedge clk);
      ta = ta || (awv && awr);
      tw = tw || (wv && wr);
      @(posedge clk);
      if (ta) awv <= 1'b0;
      if (tw) wv <= 1'b0;
    end
    do @(negedge clk); while (!bv);
    r = br;
    @(posedge clk);
    bry <= 1'b0;
  endtask

  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    arv <= 1'b1;
    ara <= a;
    rry <= 1'b1;
    do @(negedge clk); while (!arr);
    @(posedge clk);
    arv <= 1'b0;
    do @(negedge clk); while (!rv);
    d = rd;
    r = rr;
    @(posedge clk);
    rry <= 1'b0;
  endtask

  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axw(a, d, r);
  endtask

  task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    axr(a, d, r);
    chk(n, d, e);
  endtask

  // One pixel in; latency counted in cycles until the output is offered
  task automatic px(input logic [23:0] p, output int lat);
    @(posedge clk);
    pv <= 1'b1;
    pin <= p;
    do @(negedge clk); while (!opr);
    @(posedge clk);
    pv <= 1'b0;
    lat = 0;
    do begin
      @(negedge clk);
      lat++;
    end while (!opv);
  endtask

  // Red settings, control word, one pixel, expected result
  task automatic pcase(input logic [7:0] c, input logic [7:0] h, input logic [7:0] s,
                       input logic [23:0] p, input logic [23:0] e, output int lat);
    wreg(`HSA_OFS_CTRL, 32'h0);
    wreg(`HSA_OFS_HUE, {24'h0, h});
    wreg(`HSA_OFS_SAT, {24'h0, s});
    wreg(`HSA_OFS_CTRL, {24'h0, c});
    px(p, lat);
    do @(negedge clk); while (snk.q.size() == 0);
    chk("pixel", {8'h00, snk.q.pop_front()}, {8'h00, e});
  endtask

  task automatic t_regs;
    logic [7:0]  h[6] = '{8'h80, 8'h7F, 8'h01, 8'hFF, 8'h20, 8'hE0};
    logic [7:0]  s[6] = '{8'h00, 8'hFF, 8'h80, 8'h01, 8'h7F, 8'hC0};
    logic [31:0] d;
    logic [1:0]  r;
    rchk("ctrl reset", `HSA_OFS_CTRL, 32'h0);
    rchk("hue reset", `HSA_OFS_HUE, 32'h0);
    rchk("sat reset", `HSA_OFS_SAT, 32'h80);
    for (int i = 0; i < 6; i++) begin
      wreg(`HSA_OFS_CTRL, {25'h0, i[2:0], 4'h0});
      wreg(`HSA_OFS_HUE, {24'h0, h[i]});
      wreg(`HSA_OFS_SAT, {24'h0, s[i]});
    end
    // Read back after all six are written, so any crosstalk shows
    for (int i = 0; i < 6; i++) begin
      wreg(`HSA_OFS_CTRL, {25'h0, i[2:0], 4'h0});
      rchk("hue", `HSA_OFS_HUE, {{24{h[i][7]}}, h[i]});
      rchk("sat", `HSA_OFS_SAT, {24'h0, s[i]});
    end
    wreg(`HSA_OFS_CTRL, 32'h60);
    rchk("hue bad sel", `HSA_OFS_HUE, 32'h0);
    axw(8'h14, 32'h1, r);
    chk("bresp", {30'h0, r}, {30'h0, `HSA_RESP_ERR});
    axr(8'h14, d, r);
    chk("rresp", {30'h0, r}, {30'h0, `HSA_RESP_ERR});
  endtask

  // Preset loads ends on light source off, leaving all colors neutral
  task automatic t_preset;
    logic [2:0] lt[5] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h0};
    logic [7:0] eh[5] = '{`HSA_HUE_TUNG, `HSA_HUE_DAY, `HSA_HUE_D65, 8'h00, 8'h00};
    logic [7:0] es[5] = '{`HSA_SAT_TUNG, `HSA_SAT_DAY, `HSA_SAT_D65, 8'h80, 8'h80};
    for (int k = 0; k < 5; k++) begin
      wreg(`HSA_OFS_CTRL, {21'h0, lt[k], 8'h00});
      wreg(`HSA_OFS_CMD, 32'h1);
      for (int i = 0; i < 6; i++) begin
        wreg(`HSA_OFS_CTRL, {21'h0, lt[k], 1'b0, i[2:0], 4'h0});
        rchk("preset hue", `HSA_OFS_HUE, {{24{eh[k][7]}}, eh[k]});
        rchk("preset sat", `HSA_OFS_SAT, {24'h0, es[k]});
      end
    end
    rchk("cmd reads", `HSA_OFS_CMD, 32'h0);
  endtask

  // Fill against a stalled sink until refused, then drain slowly
  task automatic t_fifo;
    int          n = 0;
    logic [31:0] d;
    logic [1:0]  r;
    wreg(`HSA_OFS_CTRL, 32'h1);
    @(posedge clk);
    stall <= 1'b1;
    repeat (2) @(posedge clk);
    for (int i = 0; i < 12; i++) begin
      @(posedge clk);
      pv <= 1'b1;
      pin <= {3{i[7:0]}};
      @(negedge clk);
      if (!opr) break;
      n++;
    end
    @(posedge clk);
    pv <= 1'b0;
    chk("accepted", n, `HSA_FIFO_DEPTH + 1);
    axr(`HSA_OFS_STAT, d, r);
    chk("level full", {28'h0, d[5:2]}, 32'h8);
    @(posedge clk);
    stall <= 1'b0;
    slow <= 1'b1;
    do @(negedge clk); while (snk.q.size() < n);
    for (int i = 0; i < n; i++) begin
      chk("order", {8'h00, snk.q.pop_front()}, {8'h00, {3{i[7:0]}}});
    end
    axr(`HSA_OFS_STAT, d, r);
    chk("level empty", {28'h0, d[5:2]}, 32'h0);
    @(posedge clk);
    slow <= 1'b0;
  endtask

  // Main sequence
  initial begin
    int la;
    int lb;
    int lx;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    t_regs;
    t_preset;
    pcase(8'h00, 8'h00, 8'h00, 24'hC82828, 24'hC82828, la);
    pcase(8'h01, 8'h00, 8'h80, 24'hC82828, 24'hC82828, lb);
    chk("latency", la, lb);
    chk("latency value", la, 32'h2);
    pcase(8'h01, 8'h00, 8'h00, 24'hC82828, 24'h282828, lx);
    pcase(8'h01, 8'h00, 8'hC0, 24'h642828, 24'h822828, lx);
    pcase(8'h01, 8'h80, 8'h80, 24'hC80000, 24'hC8C800, lx);
    pcase(8'h01, 8'h40, 8'h80, 24'hC80000, 24'hC80064, lx);
    pcase(8'h01, 8'h00, 8'h00, 24'h00C800, 24'h00C800, lx);
    pcase(8'h01, 8'h00, 8'h00, 24'hC86400, 24'h646400, lx);
    pcase(8'h05, 8'h00, 8'h00, 24'hC82828, 24'hC82828, lx);
    pcase(8'h07, 8'h00, 8'h00, 24'hC82828, 24'h282828, lx);
    pcase(8'h03, 8'h00, 8'h00, 24'hC82828, 24'h282828, lx);
    pcase(8'h02, 8'h00, 8'h00, 24'hC82828, 24'hC82828, lx);
    t_fifo;
    end_of_test;
  end
endmodule
